// ===== mdc_consts.vh
// Constants for the eight-channel transfer controller.
// Assumes inclusion by bare name from the design file.
`ifndef MDC_CONSTS_VH
`define MDC_CONSTS_VH

// Controller state codes
`define MDC_ST_IDLE   2'h0
`define MDC_ST_READ   2'h1
`define MDC_ST_WRITE  2'h2

// Transfer width codes, byte step is 1 << code
`define MDC_SZ_BYTE   2'h0
`define MDC_SZ_HALF   2'h1
`define MDC_SZ_WORD   2'h2

// Transfer direction codes
`define MDC_DIR_M2M   2'h0
`define MDC_DIR_P2M   2'h1
`define MDC_DIR_M2P   2'h2

// Field widths per channel
`define MDC_PRIO_W    2
`define MDC_BURST_W   3
`define MDC_ADDR_W    32
`define MDC_DATA_W    32

// Reset values, count steps and the half-flag threshold
`define MDC_ZERO_ADDR 32'h0000_0000
`define MDC_ZERO_CNT  17'h0_0000
`define MDC_ONE_CNT   17'h0_0001
`define MDC_TWO_CNT   17'h0_0002
`define MDC_ONE_BEAT  3'h1

`endif

// ===== mdc_controller.v
// Eight-channel memory transfer controller with priority arbiter and bus master.
// Assumes configuration ports are held stable while a channel is enabled,
// and a single-outstanding bus slave answering with i_bus_ack (one-cycle pulse).
// What this block does
// - Eight independently configured channels per instance
// - Built-in arbiter picks next granted channel
// - Two-bit priority per channel, four levels
// - Equal priority: lowest channel number wins
// - Memory/peripheral directions: M2M, P2M, M2P
// - Hardware request or software trigger, selectable
// - Several peripherals may share one channel
// - Separate source/destination widths: byte, half, word
// - Circular mode restarts sequence automatically
// - Half, complete and error flags kept
// - Global flag is OR of three
// - Item count programmable up to 65536
// - Burst length of one to eight items
// - Whole transfer runs without processor help
// - Master reaches every system bus slave
`timescale 1ns/10ps
`include "mdc_consts.vh"

module mdc_controller #(
    parameter NCH      = 8,
    parameter NREQ     = 2,                   // Peripherals sharing each channel
    parameter CNT_W    = 17                   // Holds 65536
) (
    input  wire                     i_clk,
    input  wire                     i_sys_rst,
    input  wire [NCH-1:0]           i_ch_enable,
    input  wire [NCH-1:0]           i_ch_sw_mode,
    input  wire [NCH-1:0]           i_ch_sw_trig,
    input  wire [NCH-1:0]           i_ch_circular,
    input  wire [NCH*2-1:0]         i_ch_dir,
    input  wire [NCH*2-1:0]         i_channel_priority_level,
    input  wire [NCH*2-1:0]         i_ch_src_size,
    input  wire [NCH*2-1:0]         i_ch_dst_size,
    input  wire [NCH*3-1:0]         i_ch_burst,
    input  wire [NCH*CNT_W-1:0]     i_ch_count,
    input  wire [NCH*32-1:0]        i_ch_src_addr,
    input  wire [NCH*32-1:0]        i_ch_dst_addr,
    input  wire [NCH-1:0]           i_flag_clear,
    input  wire [NCH*NREQ-1:0]      i_periph_req,
    input  wire                     i_bus_ack,
    input  wire                     i_bus_err,
    input  wire [31:0]              i_bus_rdata,
    output reg                      o_bus_req,
    output reg                      o_bus_write,
    output reg  [31:0]              o_bus_addr,
    output reg  [31:0]              o_bus_wdata,
    output reg  [1:0]               o_bus_size,
    output reg  [NCH-1:0]           o_periph_ack,
    output reg  [NCH-1:0]           o_ch_active,
    output reg  [NCH-1:0]           o_ch_half,
    output reg  [NCH-1:0]           o_ch_done,
    output reg  [NCH-1:0]           o_ch_error,
    output reg  [NCH-1:0]           o_ch_global
);

    // Per-channel running state, then the shared engine state, active channel and beat count
    reg  [CNT_W-1:0]    rem      [0:NCH-1];
    reg  [31:0]         cur_src  [0:NCH-1];
    reg  [31:0]         cur_dst  [0:NCH-1];
    reg  [NCH-1:0]      sw_go;
    reg  [NCH-1:0]      enable_q;
    reg  [1:0]          state;
    reg  [2:0]          act;
    reg  [2:0]          beats;

    // Combinational arbiter outputs
    reg  [NCH-1:0]      hw_req;
    reg  [NCH-1:0]      eligible;
    reg                 found;
    reg  [2:0]          winner;
    reg  [1:0]          best_prio;
    integer             k;
    integer             r;
    // One loop index per process keeps every variable single-driven
    integer             km;
    integer             ke;
    integer             ks;

    // Shared peripheral requests merge per channel
    always @* begin
        hw_req = {NCH{1'b0}};
        for (km = 0; km < NCH; km = km + 1) begin
            for (r = 0; r < NREQ; r = r + 1) begin
                hw_req[km] = hw_req[km] | i_periph_req[km*NREQ+r];
            end
        end
    end

    // Eligibility: trigger source picked by software
    always @* begin
        eligible = {NCH{1'b0}};
        for (ke = 0; ke < NCH; ke = ke + 1) begin
            eligible[ke] = o_ch_active[ke] & i_ch_enable[ke] &
                           (i_ch_sw_mode[ke] ? sw_go[ke] : hw_req[ke]);
        end
    end

    // Scan high to low with >= so the lowest index wins a tie
    always @* begin
        found     = 1'b0;
        winner    = 3'h0;
        best_prio = 2'h0;
        for (ks = NCH - 1; ks >= 0; ks = ks - 1) begin
            if (eligible[ks] && (!found || i_channel_priority_level[ks*2 +: 2] >= best_prio)) begin
                found     = 1'b1;
                winner    = ks[2:0];
                best_prio = i_channel_priority_level[ks*2 +: 2];
            end
        end
    end

    // Values of the active channel
    wire [1:0]          a_dir    = i_ch_dir[act*2 +: 2];
    wire [1:0]          a_ssz    = i_ch_src_size[act*2 +: 2];
    wire [1:0]          a_dsz    = i_ch_dst_size[act*2 +: 2];
    wire [CNT_W-1:0]    a_cnt    = i_ch_count[act*CNT_W +: CNT_W];
    wire [CNT_W-1:0]    a_rem    = rem[act];
    wire [CNT_W-1:0]    a_left   = a_rem - `MDC_ONE_CNT;
    wire [2:0]          a_blen   = i_ch_burst[act*3 +: 3];
    wire [2:0]          beats_nx = beats + `MDC_ONE_BEAT;
    // Peripheral side keeps a fixed address, memory side steps by its width
    wire                src_inc  = (a_dir != `MDC_DIR_P2M);
    wire                dst_inc  = (a_dir != `MDC_DIR_M2P);
    wire [31:0]         src_step = src_inc ? (32'h0000_0001 << a_ssz) : `MDC_ZERO_ADDR;
    wire [31:0]         dst_step = dst_inc ? (32'h0000_0001 << a_dsz) : `MDC_ZERO_ADDR;
    // Narrow source items are zero-extended; word items pass whole, the destination bus size marks the lanes
    wire [31:0]         rd_item  = (a_ssz == `MDC_SZ_BYTE) ? {24'h00_0000, i_bus_rdata[7:0]} :
                                   (a_ssz == `MDC_SZ_HALF) ? {16'h0000, i_bus_rdata[15:0]} : i_bus_rdata;

    // Global flag source: OR of the three sticky event flags
    reg  [NCH-1:0]      next_global;
    always @* begin
        next_global = o_ch_half | o_ch_done | o_ch_error;
    end

    // Channel engine; the address alignment is left to software
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            state        <= `MDC_ST_IDLE;
            act          <= 3'h0;
            beats        <= 3'h0;
            sw_go        <= {NCH{1'b0}};
            enable_q     <= {NCH{1'b0}};
            o_bus_req    <= 1'b0;
            o_bus_write  <= 1'b0;
            o_bus_addr   <= `MDC_ZERO_ADDR;
            o_bus_wdata  <= `MDC_ZERO_ADDR;
            o_bus_size   <= `MDC_SZ_BYTE;
            o_periph_ack <= {NCH{1'b0}};
            o_ch_active  <= {NCH{1'b0}};
            o_ch_half    <= {NCH{1'b0}};
            o_ch_done    <= {NCH{1'b0}};
            o_ch_error   <= {NCH{1'b0}};
            o_ch_global  <= {NCH{1'b0}};
            for (k = 0; k < NCH; k = k + 1) begin
                rem[k]     <= `MDC_ZERO_CNT;
                cur_src[k] <= `MDC_ZERO_ADDR;
                cur_dst[k] <= `MDC_ZERO_ADDR;
            end
        end else begin
            enable_q     <= i_ch_enable;
            o_periph_ack <= {NCH{1'b0}};
            // Clears come first so a same-cycle set below wins
            o_ch_half    <= o_ch_half  & ~i_flag_clear;
            o_ch_done    <= o_ch_done  & ~i_flag_clear;
            o_ch_error   <= o_ch_error & ~i_flag_clear;
            for (k = 0; k < NCH; k = k + 1) begin
                if (i_ch_sw_trig[k]) begin
                    sw_go[k] <= 1'b1;
                end
                // Enable edge loads count and start addresses; zero count never starts
                if (i_ch_enable[k] && !enable_q[k]) begin
                    rem[k]         <= i_ch_count[k*CNT_W +: CNT_W];
                    cur_src[k]     <= i_ch_src_addr[k*32 +: 32];
                    cur_dst[k]     <= i_ch_dst_addr[k*32 +: 32];
                    o_ch_active[k] <= (i_ch_count[k*CNT_W +: CNT_W] != `MDC_ZERO_CNT);
                end else if (!i_ch_enable[k] && !(state != `MDC_ST_IDLE && act == k[2:0])) begin
                    o_ch_active[k] <= 1'b0;
                    sw_go[k]       <= 1'b0;
                end
            end
            case (state)
                `MDC_ST_IDLE: begin
                    o_bus_req <= 1'b0;
                    if (found) begin
                        act         <= winner;
                        beats       <= 3'h0;
                        state       <= `MDC_ST_READ;
                        o_bus_req   <= 1'b1;
                        o_bus_write <= 1'b0;
                        o_bus_addr  <= cur_src[winner];
                        o_bus_size  <= i_ch_src_size[winner*2 +: 2];
                    end
                end
                `MDC_ST_READ: begin
                    if (i_bus_ack) begin
                        if (i_bus_err) begin
                            o_ch_error[act]  <= 1'b1;
                            o_ch_active[act] <= 1'b0;
                            sw_go[act]       <= 1'b0;
                            o_bus_req        <= 1'b0;
                            state            <= `MDC_ST_IDLE;
                        end else begin
                            o_bus_write <= 1'b1;
                            o_bus_addr  <= cur_dst[act];
                            o_bus_wdata <= rd_item;
                            o_bus_size  <= a_dsz;
                            state       <= `MDC_ST_WRITE;
                        end
                    end
                end
                `MDC_ST_WRITE: begin
                    if (i_bus_ack) begin
                        o_bus_req <= 1'b0;
                        if (i_bus_err) begin
                            o_ch_error[act]  <= 1'b1;
                            o_ch_active[act] <= 1'b0;
                            sw_go[act]       <= 1'b0;
                            state            <= `MDC_ST_IDLE;
                        end else begin
                            rem[act]     <= a_left;
                            cur_src[act] <= cur_src[act] + src_step;
                            cur_dst[act] <= cur_dst[act] + dst_step;
                            if (a_cnt >= `MDC_TWO_CNT && a_left == (a_cnt >> 1)) begin
                                o_ch_half[act] <= 1'b1;
                            end
                            if (a_left == `MDC_ZERO_CNT) begin
                                o_ch_done[act] <= 1'b1;
                                o_periph_ack[act] <= ~i_ch_sw_mode[act];
                                state <= `MDC_ST_IDLE;
                                if (i_ch_circular[act]) begin
                                    rem[act]     <= a_cnt;
                                    cur_src[act] <= i_ch_src_addr[act*32 +: 32];
                                    cur_dst[act] <= i_ch_dst_addr[act*32 +: 32];
                                end else begin
                                    o_ch_active[act] <= 1'b0;
                                    sw_go[act]       <= 1'b0;
                                end
                            end else if (beats == a_blen) begin
                                // Compare the count itself: the next-beat value wraps at eight
                                // Burst ends: release bus for re-arbitration
                                o_periph_ack[act] <= ~i_ch_sw_mode[act];
                                state <= `MDC_ST_IDLE;
                            end else begin
                                // Next item of the burst, no processor step needed
                                beats       <= beats_nx;
                                o_bus_req   <= 1'b1;
                                o_bus_write <= 1'b0;
                                o_bus_addr  <= cur_src[act] + src_step;
                                o_bus_size  <= a_ssz;
                                state       <= `MDC_ST_READ;
                            end
                        end
                    end
                end
                default: begin
                    state     <= `MDC_ST_IDLE;
                    o_bus_req <= 1'b0;
                end
            endcase
            // Global flag trails the event flags by one cycle
            o_ch_global <= next_global;
        end
    end

endmodule

// ===== mdc_unused.v
`timescale 1ns/10ps

// ===== mdc_controller_asserts.sv
// Concurrent checks on the ports of the eight-channel transfer controller.
// Assumes one clock, synchronous active-high reset; bound to every instance.
`timescale 1ns/10ps
module mdc_controller_asserts #(
    parameter NCH   = 8,
    parameter NREQ  = 2,
    parameter CNT_W = 17
) (
    input wire logic           i_clk,
    input wire logic           i_sys_rst,
    input wire logic [NCH-1:0] i_ch_enable,
    input wire logic           i_bus_ack,
    input wire logic           i_bus_err,
    input wire logic           o_bus_req,
    input wire logic           o_bus_write,
    input wire logic [31:0]    o_bus_addr,
    input wire logic [1:0]     o_bus_size,
    input wire logic [NCH-1:0] o_periph_ack,
    input wire logic [NCH-1:0] o_ch_half,
    input wire logic [NCH-1:0] o_ch_done,
    input wire logic [NCH-1:0] o_ch_error,
    input wire logic [NCH-1:0] o_ch_global
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // Bus side: request held steady until answered, then write follows read
    req_hold_a: assert property (o_bus_req && !i_bus_ack |=> o_bus_req && $stable(o_bus_addr))
        else $error("bus request dropped or moved before acknowledge");
    read_write_a: assert property (o_bus_req && !o_bus_write && i_bus_ack && !i_bus_err |=> o_bus_req && o_bus_write)
        else $error("read item not followed by its write");
    size_legal_a: assert property (o_bus_req |-> o_bus_size != 2'h3)
        else $error("illegal transfer width on bus");
    idle_quiet_a: assert property (i_ch_enable == '0 && !o_bus_req |=> !o_bus_req)
        else $error("bus request with every channel disabled");
    ack_pulse_a: assert property (o_periph_ack != '0 |=> o_periph_ack == '0)
        else $error("peripheral acknowledge longer than one cycle");
    // Flag side: error and done tied to bus answers, global follows the three
    err_flag_a: assert property (o_bus_req && i_bus_ack && i_bus_err |-> ##[1:2] o_ch_error != '0)
        else $error("bus error did not raise a channel error flag");
    done_cause_a: assert property ((o_ch_done & ~$past(o_ch_done)) != '0 |-> $past(i_bus_ack) || $past(i_bus_ack, 2))
        else $error("complete flag raised without a bus answer");
    global_set_a: assert property ((o_ch_half | o_ch_done | o_ch_error) != '0 |-> ##[0:1] o_ch_global != '0)
        else $error("global flag missing while an event flag is set");
    global_clr_a: assert property ((o_ch_half | o_ch_done | o_ch_error) == '0 |-> ##[0:1] o_ch_global == '0)
        else $error("global flag set with no event flag");

    cover property (o_bus_req && i_bus_ack && i_bus_err);
    cover property ((o_ch_done & ~$past(o_ch_done)) != '0);
    cover property (o_periph_ack != '0);
endmodule
bind mdc_controller mdc_controller_asserts #(.NCH(NCH), .NREQ(NREQ), .CNT_W(CNT_W)) u_mdc_chk (
    .i_clk, .i_sys_rst, .i_ch_enable, .i_bus_ack, .i_bus_err, .o_bus_req, .o_bus_write, .o_bus_addr,
    .o_bus_size, .o_periph_ack, .o_ch_half, .o_ch_done, .o_ch_error, .o_ch_global);

// ===== mdc_bus_slave.sv
// Single-outstanding bus slave standing in for memories and peripherals.
// Assumes requests held until acknowledge; read data is an address pattern.
`timescale 1ns/10ps
module mdc_bus_slave (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_req,
    input  wire logic [31:0] i_addr,
    input  wire logic [3:0]  i_wait,
    input  wire logic [31:0] i_err_addr,
    output logic             o_ack,
    output logic             o_err,
    output logic [31:0]      o_rdata
);
    logic [3:0] cnt;
    initial o_rdata = 32'h0000_0000;
    // Wait states then a one-cycle answer; data toggles when not valid
    always @(posedge i_clk) begin
        if (i_sys_rst || !i_req || o_ack) begin
            cnt <= 4'h0;
            o_ack <= 1'b0;
            o_err <= 1'b0;
            o_rdata <= ~o_rdata;
        end else if (cnt == i_wait) begin
            o_ack <= 1'b1;
            o_err <= (i_addr == i_err_addr); // Error only on the chosen address
            o_rdata <= i_addr ^ 32'h5A5A_0000;
        end else begin
            cnt <= cnt + 4'h1;
            o_rdata <= ~o_rdata;
        end
    end
endmodule

// ===== testbench.sv
// Self-checking bench for the eight-channel transfer controller.
// Assumes the slave model answers reads with address ^ 5A5A_0000.
`timescale 1ns/10ps
module testbench;
    logic         i_clk, i_sys_rst, i_bus_ack, i_bus_err, o_bus_req, o_bus_write;
    logic [7:0]   i_ch_enable, i_ch_sw_mode, i_ch_sw_trig, i_ch_circular, i_flag_clear;
    logic [7:0]   o_periph_ack, o_ch_active, o_ch_half, o_ch_done, o_ch_error, o_ch_global;
    logic [15:0]  i_ch_dir, i_channel_priority_level, i_ch_src_size, i_ch_dst_size, i_periph_req;
    logic [23:0]  i_ch_burst;
    logic [135:0] i_ch_count;
    logic [255:0] i_ch_src_addr, i_ch_dst_addr;
    logic [31:0]  i_bus_rdata, o_bus_addr, o_bus_wdata, err_addr;
    logic [1:0]   o_bus_size;
    logic [3:0]   slv_wait;
    logic [66:0]  seen_q[$];
    int           miscompares = 0, cmp_count = 0, cycles = 0, pack_cnt = 0;

    mdc_controller i_mdc_controller (.i_clk, .i_sys_rst, .i_ch_enable, .i_ch_sw_mode, .i_ch_sw_trig,
        .i_ch_circular, .i_ch_dir, .i_channel_priority_level, .i_ch_src_size, .i_ch_dst_size, .i_ch_burst,
        .i_ch_count, .i_ch_src_addr, .i_ch_dst_addr, .i_flag_clear, .i_periph_req, .i_bus_ack, .i_bus_err,
        .i_bus_rdata, .o_bus_req, .o_bus_write, .o_bus_addr, .o_bus_wdata, .o_bus_size, .o_periph_ack,
        .o_ch_active, .o_ch_half, .o_ch_done, .o_ch_error, .o_ch_global);
    mdc_bus_slave i_mdc_bus_slave (.i_clk, .i_sys_rst, .i_req(o_bus_req), .i_addr(o_bus_addr),
        .i_wait(slv_wait), .i_err_addr(err_addr), .o_ack(i_bus_ack), .o_err(i_bus_err), .o_rdata(i_bus_rdata));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // Bus log, ch0 acknowledge count and hang guard
    always @(posedge i_clk) begin
        cycles++;
        if (o_bus_req && i_bus_ack)
            seen_q.push_back({o_bus_size, o_bus_write, o_bus_addr, o_bus_write ? o_bus_wdata : i_bus_rdata});
        if (o_periph_ack[0])
            pack_cnt++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cfg(input int ch, input logic [1:0] dir, pri, ssz, dsz, input logic [2:0] bur,
                       input logic [16:0] cnt, input logic [31:0] sa, da, input logic circ, hw);
        i_ch_dir[ch*2 +: 2] = dir;
        i_channel_priority_level[ch*2 +: 2] = pri;
        i_ch_src_size[ch*2 +: 2] = ssz;
        i_ch_dst_size[ch*2 +: 2] = dsz;
        i_ch_burst[ch*3 +: 3] = bur;
        i_ch_count[ch*17 +: 17] = cnt;
        i_ch_src_addr[ch*32 +: 32] = sa;
        i_ch_dst_addr[ch*32 +: 32] = da;
        i_ch_circular[ch] = circ;
        i_ch_sw_mode[ch] = ~hw;
    endtask

    task automatic go(input logic [7:0] m, input logic hw);
        i_ch_enable = i_ch_enable | m;
        tick(1);
        for (int c = 0; c < 8; c++)
            i_periph_req[c*2+1] = m[c] & hw;
        i_ch_sw_trig = hw ? 8'h00 : m;
        tick(1);
        i_ch_sw_trig = 8'h00;
    endtask

    task automatic wait_end(input int ch);
        for (int n = 0; n < 2000 && o_ch_done[ch] !== 1'b1 && o_ch_error[ch] !== 1'b1; n++)
            tick(1);
    endtask

    // Disable, let any item in flight finish, clear flags, empty the log
    task automatic stop(input logic [7:0] m);
        i_ch_enable = i_ch_enable & ~m;
        i_periph_req = 16'h0000;
        for (int n = 0; n < 100 && o_bus_req !== 1'b0; n++)
            tick(1);
        i_flag_clear = m;
        tick(1);
        i_flag_clear = 8'h00;
        tick(2);
        seen_q.delete();
        pack_cnt = 0;
    endtask

    task automatic item(input logic [31:0] sa, da, mask);
        logic [66:0] r;
        logic [66:0] w;
        r = seen_q.pop_front();
        w = seen_q.pop_front();
        chk({30'h0, r[64], w[64]}, 32'h0000_0001);
        // Destination width follows the lane mask given for the item
        chk({30'h0, w[66:65]}, mask[16] ? 32'h0000_0002 : (mask[8] ? 32'h0000_0001 : 32'h0000_0000));
        chk(r[63:32], sa);
        chk(w[63:32], da);
        chk(w[31:0] & mask, (sa ^ 32'h5A5A_0000) & mask);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        {i_ch_enable, i_ch_sw_mode, i_ch_sw_trig, i_ch_circular, i_flag_clear} = '0;
        {i_ch_dir, i_channel_priority_level, i_ch_src_size, i_ch_dst_size, i_periph_req} = '0;
        {i_ch_burst, i_ch_count, i_ch_src_addr, i_ch_dst_addr} = '0;
        err_addr = 32'hFFFF_FFFC;
        slv_wait = 4'h0;
        i_sys_rst = 1'b1;
        tick(6);
        i_sys_rst = 1'b0;
        // Every direction, word source into byte destination, sw then hw start
        for (int d = 0; d < 3; d++) begin
            cfg(2, d[1:0], 2'h0, 2'h2, 2'h0, 3'h0, 17'h0_0004, 32'h0000_1000, 32'h0000_2000, 1'b0, d != 0);
            go(8'h04, d != 0);
            wait_end(2);
            for (int k = 0; k < 4; k++)
                item(32'h0000_1000 + (d == 1 ? 0 : 4 * k), 32'h0000_2000 + (d == 2 ? 0 : k), 32'h0000_00FF);
            chk({29'h0, o_ch_half[2], o_ch_done[2], o_ch_global[2]}, 32'h0000_0007);
            stop(8'h04);
        end
        $display("test directions done");
        // Priority beats index, then lowest index wins a tie
        cfg(3, 2'h0, 2'h1, 2'h2, 2'h2, 3'h0, 17'h0_0001, 32'h0000_3300, 32'h0000_7300, 1'b0, 1'b0);
        cfg(5, 2'h0, 2'h1, 2'h2, 2'h2, 3'h0, 17'h0_0001, 32'h0000_3500, 32'h0000_7500, 1'b0, 1'b0);
        cfg(7, 2'h0, 2'h3, 2'h2, 2'h2, 3'h0, 17'h0_0001, 32'h0000_3700, 32'h0000_7700, 1'b0, 1'b0);
        go(8'hA8, 1'b0);
        wait_end(5);
        item(32'h0000_3700, 32'h0000_7700, 32'hFFFF_FFFF);
        item(32'h0000_3300, 32'h0000_7300, 32'hFFFF_FFFF);
        item(32'h0000_3500, 32'h0000_7500, 32'hFFFF_FFFF);
        stop(8'hA8);
        $display("test arbitration done");
        // Circular half-word channel runs three rounds, then flags clear
        cfg(1, 2'h0, 2'h2, 2'h1, 2'h1, 3'h1, 17'h0_0002, 32'h0000_4000, 32'h0000_8000, 1'b1, 1'b1);
        go(8'h02, 1'b1);
        for (int n = 0; n < 400 && seen_q.size() < 12; n++)
            tick(1);
        for (int k = 0; k < 6; k++)
            item(32'h0000_4000 + 2 * (k % 2), 32'h0000_8000 + 2 * (k % 2), 32'h0000_FFFF);
        chk({30'h0, o_ch_active[1], o_ch_done[1]}, 32'h0000_0003);
        stop(8'h02);
        chk({29'h0, o_ch_half[1], o_ch_done[1], o_ch_global[1]}, 32'h0000_0000);
        $display("test circular done");
        // Slow slave, error on second read stops the channel
        slv_wait = 4'h3;
        err_addr = 32'h0000_5004;
        cfg(4, 2'h0, 2'h0, 2'h2, 2'h2, 3'h7, 17'h0_0003, 32'h0000_5000, 32'h0000_9000, 1'b0, 1'b0);
        go(8'h10, 1'b0);
        wait_end(4);
        tick(2);
        chk({28'h0, o_ch_error[4], o_ch_active[4], o_ch_global[4], o_ch_done[4]}, 32'h0000_000A);
        chk(seen_q.size(), 32'h0000_0003);
        stop(8'h10);
        slv_wait = 4'h0;
        err_addr = 32'hFFFF_FFFC;
        $display("test error done");
        // Bursts of three items over six: two peripheral acknowledges
        cfg(0, 2'h0, 2'h0, 2'h2, 2'h2, 3'h2, 17'h0_0006, 32'h0000_6000, 32'h0000_A000, 1'b0, 1'b1);
        go(8'h01, 1'b1);
        wait_end(0);
        tick(2);
        chk(pack_cnt, 32'h0000_0002);
        stop(8'h01);
        $display("test burst done");
        summarize();
    end
endmodule
